// *** design/dpa_access_control.sv ***
// Parameter reset, channel lock, arbitration and movement range keeper.
// Assumes inputs from pins are raw; parameter port and moves come from same-clock logic.
module dpa_access_control #(
  parameter int NUM_PARAMS = 8
)
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  // Parameter port from fieldbus
  input wire logic PAR_WR_IN,
  input wire logic PAR_RD_IN,
  input wire logic [15:0] PAR_ADDR_IN,
  input wire logic [15:0] PAR_WDATA_IN,
  output logic [15:0] PAR_RDATA_OUT,
  output logic PAR_ERR_OUT,
  // Drive state
  input wire logic POWER_STAGE_EN_IN,
  input wire logic COMMISSION_EXCL_REQ_IN,
  input wire logic FACTORY_RESTORE_IN,
  input wire logic SCALE_NUM_WR_IN,
  input wire logic [31:0] SCALE_NUM_IN,
  input wire logic [31:0] SCALE_DENOM_IN,
  // Channel actions
  input wire dpa_pkg::dpa_safe_in_t SAFE_PIN_IN,
  input wire dpa_pkg::dpa_ctl_in_t DIN_CTL_IN,
  input wire dpa_pkg::dpa_ctl_in_t SW_CTL_IN,
  output dpa_pkg::dpa_safe_in_t SAFE_OUT,
  output dpa_pkg::dpa_ctl_in_t CTL_OUT,
  output logic FIELDBUS_EXCL_OUT,
  output logic COMMISSION_EXCL_OUT,
  // Movement
  input wire dpa_pkg::dpa_mode_t MODE_IN,
  input wire dpa_pkg::dpa_move_t MOVE_IN,
  input wire logic HOME_SET_IN,
  input wire logic [31:0] HOME_POS_IN,
  input wire logic JOG_TICK_IN,
  input wire logic signed [31:0] JOG_DELTA_IN,
  output logic signed [31:0] POSITION_OUT,
  output logic signed [31:0] TARGET_OUT,
  output logic MOVE_START_OUT,
  output logic MOVE_REFUSED_OUT,
  output logic ZERO_VALID_OUT,
  // Parameter management
  output logic DEFAULTS_APPLY_OUT,
  output logic NV_WRITE_OUT,
  output logic FACTORY_PENDING_OUT,
  output logic [31:0] SCALE_NUM_OUT,
  output logic [31:0] SCALE_DENOM_OUT
);
  initial
  begin
    if (NUM_PARAMS < 1)
    begin
      $error("NUM_PARAMS must be positive");
    end
  end

  dpa_pkg::dpa_safe_in_t safe_s1;
  dpa_pkg::dpa_safe_in_t safe_s2;
  dpa_pkg::dpa_ctl_in_t din_s1;
  dpa_pkg::dpa_ctl_in_t din_s2;
  logic [15:0] lock_ctrl;
  logic [15:0] reset_ctrl;
  logic reset_pending;
  logic pstage_d;
  logic sw_excl;
  logic signed [31:0] position;
  logic wr_lock;
  logic wr_reset;
  logic reset_ok;
  logic target_in_range;
  logic signed [30:0] pos31;
  logic signed [30:0] next_pos31;

  function automatic logic in_range(input logic signed [31:0] v);
    in_range = (v >= dpa_pkg::POS_MIN) && (v <= dpa_pkg::POS_MAX);
  endfunction

  // Pin inputs pass two flip-flops
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      safe_s1 <= '0;
      safe_s2 <= '0;
      din_s1 <= '0;
      din_s2 <= '0;
    end
    else
    begin
      safe_s1 <= SAFE_PIN_IN;
      safe_s2 <= safe_s1;
      din_s1 <= DIN_CTL_IN;
      din_s2 <= din_s1;
    end
  end

  assign wr_lock = PAR_WR_IN && (PAR_ADDR_IN == dpa_pkg::CHANNEL_LOCK_CONTROL_ADDR);
  assign wr_reset = PAR_WR_IN && (PAR_ADDR_IN == dpa_pkg::USER_SETTINGS_RESET_CONTROL_ADDR);
  // Range check and power stage gate on the reset control
  assign reset_ok = !POWER_STAGE_EN_IN && (PAR_WDATA_IN <= dpa_pkg::RESET_CTRL_MAX);

  // Channel lock register, effective at once
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      lock_ctrl <= dpa_pkg::LOCK_RESET;
    end
    else if (wr_lock && PAR_WDATA_IN <= dpa_pkg::LOCK_CTRL_MAX && !sw_excl)
    begin
      lock_ctrl <= PAR_WDATA_IN;
    end
  end

  // Commissioning exclusive switch; refused while fieldbus holds the lock
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      sw_excl <= 1'b0;
    end
    else
    begin
      sw_excl <= COMMISSION_EXCL_REQ_IN && (sw_excl || !lock_ctrl[0]);
    end
  end

  // User reset control; pending until the next power stage enable
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      reset_ctrl <= dpa_pkg::RESET_CTRL_RESET;
      reset_pending <= 1'b0;
      pstage_d <= 1'b0;
      DEFAULTS_APPLY_OUT <= 1'b0;
    end
    else
    begin
      pstage_d <= POWER_STAGE_EN_IN;
      DEFAULTS_APPLY_OUT <= 1'b0;
      if (wr_reset && reset_ok)
      begin
        reset_ctrl <= PAR_WDATA_IN;
        if (PAR_WDATA_IN[dpa_pkg::RESET_USER_BIT])
        begin
          reset_pending <= 1'b1;
        end
      end
      else if (POWER_STAGE_EN_IN && !pstage_d && reset_pending)
      begin
        // Defaults go live on enable edge only; protected groups untouched downstream
        DEFAULTS_APPLY_OUT <= 1'b1;
        reset_pending <= 1'b0;
      end
    end
  end

  // Defaults never reach nonvolatile storage from here
  assign NV_WRITE_OUT = 1'b0;

  // Factory restore replaces active and stored values after power cycle
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      FACTORY_PENDING_OUT <= 1'b0;
    end
    else if (FACTORY_RESTORE_IN)
    begin
      FACTORY_PENDING_OUT <= 1'b1;
    end
  end

  // Scaling activates on numerator write while the power stage is disabled; downstream reinterprets user units
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      SCALE_NUM_OUT <= 32'h00000001;
      SCALE_DENOM_OUT <= 32'h00004000;
    end
    else if (SCALE_NUM_WR_IN && !POWER_STAGE_EN_IN)
    begin
      SCALE_NUM_OUT <= SCALE_NUM_IN;
      SCALE_DENOM_OUT <= SCALE_DENOM_IN;
    end
  end

  // Parameter readback
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      PAR_RDATA_OUT <= '0;
      PAR_ERR_OUT <= 1'b0;
    end
    else
    begin
      PAR_ERR_OUT <= (wr_reset && !reset_ok) || (wr_lock && PAR_WDATA_IN > dpa_pkg::LOCK_CTRL_MAX);
      if (PAR_RD_IN && PAR_ADDR_IN == dpa_pkg::CHANNEL_LOCK_CONTROL_ADDR)
      begin
        PAR_RDATA_OUT <= lock_ctrl;
      end
      else if (PAR_RD_IN && PAR_ADDR_IN == dpa_pkg::USER_SETTINGS_RESET_CONTROL_ADDR)
      begin
        PAR_RDATA_OUT <= reset_ctrl;
      end
      else if (PAR_RD_IN)
      begin
        PAR_RDATA_OUT <= '0;
      end
    end
  end

  // Safety and state inputs are never gated by exclusive access
  assign SAFE_OUT = safe_s2;
  // Lock blocks digital inputs and software; software exclusive blocks inputs
  always_comb
  begin
    if (lock_ctrl[0])
    begin
      CTL_OUT = '0;
    end
    else if (sw_excl)
    begin
      CTL_OUT = SW_CTL_IN;
    end
    else
    begin
      CTL_OUT = din_s2 | SW_CTL_IN;
    end
  end
  assign FIELDBUS_EXCL_OUT = lock_ctrl[0];
  assign COMMISSION_EXCL_OUT = sw_excl;

  // Movement range
  assign pos31 = position[30:0];
  assign next_pos31 = pos31 + JOG_DELTA_IN[30:0];
  assign target_in_range = in_range(MOVE_IN.relative ? (position + MOVE_IN.target) : MOVE_IN.target);

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      position <= '0;
      ZERO_VALID_OUT <= 1'b0;
      TARGET_OUT <= '0;
      MOVE_START_OUT <= 1'b0;
      MOVE_REFUSED_OUT <= 1'b0;
    end
    else
    begin
      MOVE_START_OUT <= 1'b0;
      MOVE_REFUSED_OUT <= 1'b0;
      if (MODE_IN == dpa_pkg::MODE_HOMING && HOME_SET_IN)
      begin
        position <= HOME_POS_IN;
        ZERO_VALID_OUT <= 1'b1;
      end
      else if (MOVE_IN.start)
      begin
        if (target_in_range)
        begin
          TARGET_OUT <= MOVE_IN.relative ? position + MOVE_IN.target : MOVE_IN.target;
          MOVE_START_OUT <= 1'b1;
        end
        else if (MODE_IN == dpa_pkg::MODE_PROFILE && !MOVE_IN.relative)
        begin
          MOVE_REFUSED_OUT <= 1'b1;
        end
        else
        begin
          // Out-of-range relative, or absolute outside profile mode: rezero then move from zero
          position <= '0;
          TARGET_OUT <= MOVE_IN.target;
          MOVE_START_OUT <= 1'b1;
          ZERO_VALID_OUT <= 1'b0;
        end
      end
      else if (MODE_IN == dpa_pkg::MODE_JOG && JOG_TICK_IN)
      begin
        position <= {{1{next_pos31[30]}}, next_pos31};
        if (!in_range(position + JOG_DELTA_IN))
        begin
          ZERO_VALID_OUT <= 1'b0;
        end
      end
    end
  end
  assign POSITION_OUT = position;

  a_reset_reject: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (wr_reset && POWER_STAGE_EN_IN) |=> $stable(reset_ctrl)) else $error("reset ctrl changed");
  a_reset_range: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    reset_ctrl <= 16'h0007) else $error("reset ctrl out of range");
  a_defaults_edge: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    DEFAULTS_APPLY_OUT |-> $past(POWER_STAGE_EN_IN) && !$past(pstage_d)) else $error("bad apply");
  a_nv_never: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    !NV_WRITE_OUT) else $error("nv write");
  a_lock_blocks: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    lock_ctrl[0] |-> CTL_OUT == '0) else $error("lock leak");
  a_one_excl: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    !(FIELDBUS_EXCL_OUT && COMMISSION_EXCL_OUT)) else $error("two exclusive");
  a_halt_pass: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    SAFE_OUT.halt == $past(safe_s1.halt)) else $error("halt blocked");
  a_abs_refuse: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (MOVE_IN.start && !target_in_range && MODE_IN == dpa_pkg::MODE_PROFILE && !MOVE_IN.relative
     && !HOME_SET_IN) |=> MOVE_REFUSED_OUT && !MOVE_START_OUT) else $error("abs not refused");
  a_lock_write: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (wr_lock && PAR_WDATA_IN == 16'h0001 && !sw_excl) |=> lock_ctrl == 16'h0001) else $error("lock");
endmodule

// *** design/dpa_pkg.sv ***
// Package for drive parameter and access control: offsets, fields, types.
// Assumes a single 40 MHz clock domain and a word-wide parameter port.
package dpa_pkg;
  // Parameter addresses
  localparam logic [15:0] CHANNEL_LOCK_CONTROL_ADDR = 16'h013c;
  localparam logic [15:0] USER_SETTINGS_RESET_CONTROL_ADDR = 16'h0410;
  // Field positions and limits
  localparam int RESET_USER_BIT = 0;
  localparam logic [15:0] RESET_CTRL_MAX = 16'h0007;
  localparam logic [15:0] LOCK_CTRL_MAX = 16'h0001;
  localparam logic [15:0] LOCK_RESET = 16'h0000;
  localparam logic [15:0] RESET_CTRL_RESET = 16'h0000;
  // Movement range under factory scaling
  localparam logic signed [31:0] POS_MIN = 32'shc0000000;
  localparam logic signed [31:0] POS_MAX = 32'sh3fffffff;
  localparam int INCR_PER_REV = 32768;
  localparam int POS_WIDTH = 31;

  typedef enum logic [1:0] {MODE_JOG, MODE_PROFILE, MODE_HOMING, MODE_OTHER} dpa_mode_t;

  typedef struct packed {
    logic halt;
    logic fault_reset;
    logic enable;
    logic positive_travel_limit_input;
    logic negative_travel_limit_input;
    logic homing_switch;
    logic sto_a;
    logic sto_b;
  } dpa_safe_in_t;

  typedef struct packed {
    logic jog_pos;
    logic jog_neg;
    logic jog_fast;
  } dpa_ctl_in_t;

  typedef struct packed {
    logic start;
    logic relative;
    logic step;
    logic signed [31:0] target;
  } dpa_move_t;
endpackage

// *** test/dpa_fb_model.sv ***
// Fieldbus controller model: one-cycle parameter writes and reads.
// Assumes callers start 2 ns after a rising clock edge.
module dpa_fb_model
(
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  input wire logic err_in,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end
  // Held across one edge; strobes then drop and address and data show the inverse so stale data never looks valid
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic e);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(posedge clk_in);
    #2;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
    q = rdata_in;
    e = err_in;
    // Idle edge so back-to-back calls never reassign a strobe in one time step
    @(posedge clk_in);
    #2;
  endtask
endmodule

// *** test/tb_drive_param_access_control.sv ***
// Bench for the parameter and access control block with a fieldbus model.
// Assumes one 40 MHz clock; inputs change 2 ns after rising edges.
module tb_drive_param_access_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, err, stage, cexcl, hset, jtick;
  logic [15:0] addr, wdata, rdata, q;
  logic e, seen;
  logic [31:0] hpos, rs;
  logic signed [31:0] jdelta, pos, tgt;
  dpa_pkg::dpa_safe_in_t safe_i, safe_o;
  dpa_pkg::dpa_ctl_in_t din, sw, ctl;
  dpa_pkg::dpa_mode_t mode;
  dpa_pkg::dpa_move_t mv;
  logic fbx, cx, mstart, mref, zv, dapp, nvw;
  logic frest, swr, fpend;
  logic [31:0] snum, sden;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  dpa_fb_model fb_u (.clk_in(clk), .rdata_in(rdata), .err_in(err), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  // Scaling values fixed; only the write strobe varies
  dpa_access_control dut_u (.MCLK_IN(clk), .RST_N_IN(rst_n), .PAR_WR_IN(wr), .PAR_RD_IN(rd),
    .PAR_ADDR_IN(addr), .PAR_WDATA_IN(wdata), .PAR_RDATA_OUT(rdata), .PAR_ERR_OUT(err),
    .POWER_STAGE_EN_IN(stage), .COMMISSION_EXCL_REQ_IN(cexcl), .FACTORY_RESTORE_IN(frest),
    .SCALE_NUM_WR_IN(swr), .SCALE_NUM_IN(32'h00000003), .SCALE_DENOM_IN(32'h00008000),
    .SAFE_PIN_IN(safe_i), .DIN_CTL_IN(din), .SW_CTL_IN(sw), .SAFE_OUT(safe_o), .CTL_OUT(ctl),
    .FIELDBUS_EXCL_OUT(fbx), .COMMISSION_EXCL_OUT(cx), .MODE_IN(mode), .MOVE_IN(mv),
    .HOME_SET_IN(hset), .HOME_POS_IN(hpos), .JOG_TICK_IN(jtick), .JOG_DELTA_IN(jdelta),
    .POSITION_OUT(pos), .TARGET_OUT(tgt), .MOVE_START_OUT(mstart), .MOVE_REFUSED_OUT(mref),
    .ZERO_VALID_OUT(zv), .DEFAULTS_APPLY_OUT(dapp), .NV_WRITE_OUT(nvw),
    .FACTORY_PENDING_OUT(fpend), .SCALE_NUM_OUT(snum), .SCALE_DENOM_OUT(sden));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic home(input logic [31:0] p);
    mode = dpa_pkg::MODE_HOMING;
    hpos = p;
    hset = 1'b1;
    step(1);
    hset = 1'b0;
  endtask
  task automatic summarize();
    $display("Counts: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard well above the roughly 50 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end
  initial
  begin
    rs = 32'd93;
    {stage, cexcl, hset, jtick, hpos, jdelta, safe_i, din, sw, frest, swr} = '0;
    mode = dpa_pkg::MODE_OTHER;
    mv = '0;
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    fb_u.acc(1'b0, dpa_pkg::CHANNEL_LOCK_CONTROL_ADDR, 16'h0000, q, e);
    chk(q, dpa_pkg::LOCK_RESET);
    chk({fbx, cx, zv}, 3'b000);
    fb_u.acc(1'b0, 16'h0222, 16'h0000, q, e);
    chk(q, 16'h0000);
    chk({fpend, snum, sden}, {1'b0, 32'h00000001, 32'h00004000});
    $display("test reset done");
    stage = 1'b1;
    fb_u.acc(1'b1, dpa_pkg::USER_SETTINGS_RESET_CONTROL_ADDR, 16'h0001, q, e);
    chk(e, 1'b1);
    stage = 1'b0;
    fb_u.acc(1'b1, dpa_pkg::USER_SETTINGS_RESET_CONTROL_ADDR, 16'(rnd()) | 16'h0008, q, e);
    chk(e, 1'b1);
    fb_u.acc(1'b1, dpa_pkg::USER_SETTINGS_RESET_CONTROL_ADDR, 16'h0007, q, e);
    chk(e, 1'b0);
    fb_u.acc(1'b0, dpa_pkg::USER_SETTINGS_RESET_CONTROL_ADDR, 16'h0000, q, e);
    chk(q, 16'h0007);
    step(3);
    chk(dapp, 1'b0);
    stage = 1'b1;
    seen = 1'b0;
    repeat (3)
    begin
      step(1);
      seen = seen | dapp;
    end
    chk(seen, 1'b1);
    chk(nvw, 1'b0);
    stage = 1'b0;
    $display("test user reset done");
    rs = rnd();
    sw = rs[2:0];
    step(3);
    chk(ctl, sw);
    fb_u.acc(1'b1, dpa_pkg::CHANNEL_LOCK_CONTROL_ADDR, 16'h0001, q, e);
    chk({fbx, ctl}, 4'h8);
    cexcl = 1'b1;
    rs = rnd();
    safe_i = rs[7:0];
    step(3);
    chk(cx, 1'b0);
    chk(safe_o, safe_i);
    fb_u.acc(1'b1, dpa_pkg::CHANNEL_LOCK_CONTROL_ADDR, 16'h0002, q, e);
    chk(e, 1'b1);
    fb_u.acc(1'b1, dpa_pkg::CHANNEL_LOCK_CONTROL_ADDR, 16'h0000, q, e);
    step(2);
    chk(cx, 1'b1);
    fb_u.acc(1'b1, dpa_pkg::CHANNEL_LOCK_CONTROL_ADDR, 16'h0001, q, e);
    chk(fbx, 1'b0);
    cexcl = 1'b0;
    step(2);
    $display("test lock done");
    home(dpa_pkg::POS_MAX);
    chk({pos, zv}, {dpa_pkg::POS_MAX, 1'b1});
    mode = dpa_pkg::MODE_JOG;
    jdelta = 32'sd1;
    jtick = 1'b1;
    step(1);
    jtick = 1'b0;
    chk(pos, dpa_pkg::POS_MIN);
    chk(zv, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      home(dpa_pkg::POS_MAX);
      mode = i ? dpa_pkg::MODE_JOG : dpa_pkg::MODE_PROFILE;
      mv = '{start: 1'b1, relative: 1'b1, step: i[0], target: {16'h0000, 16'(rnd()) | 16'h0001}};
      step(1);
      mv.start = 1'b0;
      chk({mstart, pos, zv}, {1'b1, 32'h00000000, 1'b0});
      chk(tgt, mv.target);
    end
    mode = dpa_pkg::MODE_PROFILE;
    mv = '{start: 1'b1, relative: 1'b0, step: 1'b0, target: dpa_pkg::POS_MAX + 32'sd1};
    step(1);
    mv.start = 1'b0;
    chk({mref, mstart}, 2'b10);
    $display("test movement done");
    frest = 1'b1;
    swr = 1'b1;
    step(1);
    frest = 1'b0;
    swr = 1'b0;
    chk({fpend, snum, sden}, {1'b1, 32'h00000003, 32'h00008000});
    $display("test restore and scaling done");
    summarize();
  end
endmodule
